/* logic/cwmp_pkg.sv */
package cwmp_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int CWMP_CH_NUM   = 16;
  localparam int CWMP_CODE_W   = 4;
  localparam int CWMP_REG_W    = 16;
  localparam int CWMP_DATA_W   = 32;
  localparam int CWMP_ADDR_W   = 12;
  localparam int CWMP_IDX_W    = 10;
  localparam int CWMP_PH_REGS  = 4;
  localparam int CWMP_CH_PER_R = 4;
  localparam int CWMP_DEG_W    = 12;
  localparam int CWMP_MULT_W   = 5;

  // ***************************************************************
  // Register indices; byte address is four times the index
  // ***************************************************************
  localparam logic [9:0]  CWMP_IDX_CTRL  = 10'h0C0;
  localparam logic [9:0]  CWMP_IDX_PH0   = 10'h0C1;
  localparam logic [9:0]  CWMP_IDX_PH1   = 10'h0C2;
  localparam logic [9:0]  CWMP_IDX_PH2   = 10'h0C3;
  localparam logic [9:0]  CWMP_IDX_PH3   = 10'h0C4;
  localparam logic [11:0] CWMP_ADDR_CTRL = {CWMP_IDX_CTRL, 2'b00};
  localparam logic [11:0] CWMP_ADDR_PH0  = {CWMP_IDX_PH0, 2'b00};
  localparam logic [11:0] CWMP_ADDR_PH1  = {CWMP_IDX_PH1, 2'b00};
  localparam logic [11:0] CWMP_ADDR_PH2  = {CWMP_IDX_PH2, 2'b00};
  localparam logic [11:0] CWMP_ADDR_PH3  = {CWMP_IDX_PH3, 2'b00};

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int              CWMP_CTRL_MODE_BIT  = 0;
  localparam int              CWMP_CTRL_RATIO_LSB = 1;
  localparam logic [15:0]     CWMP_PH_RST         = 16'h0000;
  localparam logic [11:0]     CWMP_PHASE_STEP     = 12'h0_0E1;
  localparam logic [31:0]     CWMP_RD_ZERO        = 32'h0000_0000;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic {CWMP_MODE_TGC, CWMP_MODE_CW} cwmp_mode_t;
  typedef enum logic [1:0] {CWMP_RATIO_16X, CWMP_RATIO_8X, CWMP_RATIO_4X,
                            CWMP_RATIO_1X} cwmp_ratio_t;
  typedef enum logic {CWMP_APB_IDLE, CWMP_APB_ACCESS} cwmp_apb_st_t;

  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [CWMP_ADDR_W-1:0] paddr;
    logic [CWMP_DATA_W-1:0] pwdata;
    logic [3:0]             pstrb;
  } cwmp_apb_req_t;

  typedef struct packed {
    logic                   pready;
    logic [CWMP_DATA_W-1:0] prdata;
    logic                   pslverr;
  } cwmp_apb_rsp_t;

  typedef struct packed {
    logic                  wrEn;
    logic [CWMP_IDX_W-1:0] idx;
    logic [CWMP_REG_W-1:0] wdata;
    logic [1:0]            strb;
  } cwmp_reg_acc_t;

endpackage : cwmp_pkg

/* logic/cwmp_apb_slave.sv */
`timescale 1ns/10ps
module cwmp_apb_slave
  import cwmp_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire cwmp_apb_req_t         apbReq,
  input  wire logic [CWMP_REG_W-1:0] rdData,
  input  wire logic                  addrHit,
  output cwmp_reg_acc_t              regAcc,
  output cwmp_apb_rsp_t              apbRsp
);

  typedef struct packed {
    cwmp_apb_st_t           st;
    logic [CWMP_DATA_W-1:0] prdata;
    logic                   err;
  } cwmp_slv_state_t;

  cwmp_slv_state_t cur_ff;
  cwmp_slv_state_t nxt_cur;
  logic            accessDone;
  logic            goodAddr;

  // ***************************************************************
  // Decode
  // ***************************************************************
  assign goodAddr   = addrHit && (apbReq.paddr[1:0] == 2'b00);
  assign accessDone = (cur_ff.st == CWMP_APB_ACCESS) && apbReq.psel && apbReq.penable;

  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      CWMP_APB_IDLE: begin
        if (apbReq.psel && !apbReq.penable) begin
          nxt_cur.st     = CWMP_APB_ACCESS;
          nxt_cur.err    = !goodAddr;
          nxt_cur.prdata = (goodAddr && !apbReq.pwrite) ? {16'h0000, rdData} : CWMP_RD_ZERO;
        end
      end
      CWMP_APB_ACCESS: begin
        if (accessDone || !apbReq.psel) begin
          nxt_cur.st = CWMP_APB_IDLE;
        end
      end
      default: begin
        nxt_cur.st = CWMP_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{st: CWMP_APB_IDLE, prdata: CWMP_RD_ZERO, err: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Write lands on the access edge only, unmapped writes dropped
  assign regAcc.wrEn  = accessDone && apbReq.pwrite && !cur_ff.err;
  assign regAcc.idx   = apbReq.paddr[CWMP_ADDR_W-1:2];
  assign regAcc.wdata = apbReq.pwdata[CWMP_REG_W-1:0];
  assign regAcc.strb  = apbReq.pstrb[1:0];

  assign apbRsp.pready  = accessDone;
  assign apbRsp.prdata  = cur_ff.prdata;
  assign apbRsp.pslverr = accessDone && cur_ff.err;

endmodule : cwmp_apb_slave

/* logic/cwmp_phase_decode.sv */
`timescale 1ns/10ps
module cwmp_phase_decode
  import cwmp_pkg::*;
(
  input  wire logic                                     sys_clk,
  input  wire logic                                     rst_n,
  input  wire logic [CWMP_CH_NUM-1:0][CWMP_CODE_W-1:0]  phaseCode,
  input  wire cwmp_mode_t                               modeSel,
  input  wire cwmp_ratio_t                              ratioSel,
  output logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0]       phaseTapOneHot,
  output logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]        phaseTenthDeg,
  output logic [CWMP_MULT_W-1:0]                        clockMultiple
);

  typedef struct packed {
    logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0] tap;
    logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]  deg;
    logic [CWMP_MULT_W-1:0]                  mult;
  } cwmp_dec_state_t;

  cwmp_dec_state_t                         cur_ff;
  cwmp_dec_state_t                         nxt_cur;
  logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0] tapRaw;
  logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]  degRaw;

  // ***************************************************************
  // Per-channel phase tap and angle
  // ***************************************************************
  for (genvar ch = 0; ch < CWMP_CH_NUM; ch++) begin : g_ch
    // Code N picks tap N in CW mode (no tap in TGC), angle N x 22.5 deg in tenths [RULE5]
    assign tapRaw[ch] = (modeSel == CWMP_MODE_CW) ? (16'h0001 << phaseCode[ch]) : 16'h0000; // [RULE7]
    assign degRaw[ch] = 12'(CWMP_PHASE_STEP * phaseCode[ch]); // [RULE5]
  end

  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.tap = tapRaw;
    nxt_cur.deg = degRaw;
    case (ratioSel) // [RULE8]
      CWMP_RATIO_16X: nxt_cur.mult = 5'h10;
      CWMP_RATIO_8X:  nxt_cur.mult = 5'h08;
      CWMP_RATIO_4X:  nxt_cur.mult = 5'h04;
      CWMP_RATIO_1X:  nxt_cur.mult = 5'h01;
      default:        nxt_cur.mult = 5'h10;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign phaseTapOneHot = cur_ff.tap;
  assign phaseTenthDeg  = cur_ff.deg;
  assign clockMultiple  = cur_ff.mult;

endmodule : cwmp_phase_decode

/* logic/cwmp_mixer_phase_regs.sv */
// Overview of operation
// RULE1 - Index C1h holds channel 1-4 codes in nibbles 3-0 up to 15-12.
// RULE2 - Index C2h holds channel 5-8 codes in nibbles 3-0 up to 15-12.
// RULE3 - Index C3h holds channel 9-12 codes in nibbles 3-0 up to 15-12.
// RULE4 - Index C4h holds channel 13-16 codes in nibbles 3-0 up to 15-12.
// RULE5 - Code N selects a mixer phase shift of N times 22.5 degrees.
// RULE6 - All phase fields are read/write and clear to zero on reset.
// RULE7 - Mode bit: 0 selects TGC, 1 selects CW; phases matter only in CW.
// RULE8 - Clock mode field: 00 16X, 01 8X, 10 4X, 11 1X.
// RULE9 - Stored codes drive mixer phase outputs, updated after the write completes.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module cwmp_mixer_phase_regs
  import cwmp_pkg::*;
(
  input  wire logic                                     sys_clk,
  input  wire logic                                     rst_n,
  input  wire cwmp_apb_req_t                            apbReq,
  output cwmp_apb_rsp_t                                 apbRsp,
  output logic [CWMP_CH_NUM-1:0][CWMP_CODE_W-1:0]       mixerPhaseCode,
  output logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0]       mixerPhaseTap,
  output logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]        mixerPhaseTenthDeg,
  output logic                                          continuousWaveModeSelect,
  output logic [1:0]                                    continuousWaveClockRatio,
  output logic [CWMP_MULT_W-1:0]                        continuousWaveClockMultiple
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    cwmp_mode_t                             mode;
    cwmp_ratio_t                            ratio;
    logic [CWMP_PH_REGS-1:0][CWMP_REG_W-1:0] phase;
  } cwmp_regs_state_t;

  cwmp_regs_state_t      cur_ff;
  cwmp_regs_state_t      nxt_cur;
  cwmp_reg_acc_t         regAcc;
  logic [CWMP_REG_W-1:0] rdData;
  logic                  addrHit;
  logic [CWMP_REG_W-1:0] laneMask;

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  cwmp_apb_slave u_apb_slave (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .apbReq  (apbReq),
    .rdData  (rdData),
    .addrHit (addrHit),
    .regAcc  (regAcc),
    .apbRsp  (apbRsp)
  );

  // ***************************************************************
  // Address decode and read mux
  // ***************************************************************
  always_comb begin
    addrHit = 1'b1;
    rdData  = 16'h0000;
    case (regAcc.idx)
      CWMP_IDX_CTRL: begin
        rdData[CWMP_CTRL_MODE_BIT]                    = cur_ff.mode;  // [RULE7]
        rdData[CWMP_CTRL_RATIO_LSB+1:CWMP_CTRL_RATIO_LSB] = cur_ff.ratio; // [RULE8]
      end
      CWMP_IDX_PH0: rdData = cur_ff.phase[0]; // [RULE1] [RULE6]
      CWMP_IDX_PH1: rdData = cur_ff.phase[1]; // [RULE2] [RULE6]
      CWMP_IDX_PH2: rdData = cur_ff.phase[2]; // [RULE3] [RULE6]
      CWMP_IDX_PH3: rdData = cur_ff.phase[3]; // [RULE4] [RULE6]
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // Byte lanes from pstrb, low two bytes only
  assign laneMask = {{8{regAcc.strb[1]}}, {8{regAcc.strb[0]}}};

  // ***************************************************************
  // Register update
  // ***************************************************************
  always_comb begin
    nxt_cur = cur_ff;
    if (regAcc.wrEn) begin
      case (regAcc.idx)
        CWMP_IDX_CTRL: begin
          if (regAcc.strb[0]) begin
            nxt_cur.mode  = cwmp_mode_t'(regAcc.wdata[CWMP_CTRL_MODE_BIT]); // [RULE7]
            nxt_cur.ratio = cwmp_ratio_t'(
              regAcc.wdata[CWMP_CTRL_RATIO_LSB+1:CWMP_CTRL_RATIO_LSB]); // [RULE8]
          end
        end
        CWMP_IDX_PH0: begin
          nxt_cur.phase[0] = (cur_ff.phase[0] & ~laneMask) | (regAcc.wdata & laneMask); // [RULE1]
        end
        CWMP_IDX_PH1: begin
          nxt_cur.phase[1] = (cur_ff.phase[1] & ~laneMask) | (regAcc.wdata & laneMask); // [RULE2]
        end
        CWMP_IDX_PH2: begin
          nxt_cur.phase[2] = (cur_ff.phase[2] & ~laneMask) | (regAcc.wdata & laneMask); // [RULE3]
        end
        CWMP_IDX_PH3: begin
          nxt_cur.phase[3] = (cur_ff.phase[3] & ~laneMask) | (regAcc.wdata & laneMask); // [RULE4]
        end
        default: begin
          nxt_cur = cur_ff;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff.mode  <= CWMP_MODE_TGC;
      cur_ff.ratio <= CWMP_RATIO_16X;
      cur_ff.phase <= {CWMP_PH_REGS{CWMP_PH_RST}}; // [RULE6]
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ***************************************************************
  // Channel outputs
  // ***************************************************************
  // Register r nibble k is channel 4r+k+1
  for (genvar ch = 0; ch < CWMP_CH_NUM; ch++) begin : g_code
    assign mixerPhaseCode[ch] =
      cur_ff.phase[ch / CWMP_CH_PER_R][(ch % CWMP_CH_PER_R) * CWMP_CODE_W +: CWMP_CODE_W]; // [RULE9]
  end

  assign continuousWaveModeSelect = cur_ff.mode;
  assign continuousWaveClockRatio = cur_ff.ratio;

  cwmp_phase_decode u_phase_decode (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .phaseCode      (mixerPhaseCode),
    .modeSel        (cur_ff.mode),
    .ratioSel       (cur_ff.ratio),
    .phaseTapOneHot (mixerPhaseTap),
    .phaseTenthDeg  (mixerPhaseTenthDeg),
    .clockMultiple  (continuousWaveClockMultiple)
  );

endmodule : cwmp_mixer_phase_regs

/* bench/cwmp_mixer_phase_regs_assertions.sv */
`timescale 1ns/10ps
module cwmp_mixer_phase_regs_chk
  import cwmp_pkg::*;
(
  input wire logic                                    sys_clk,
  input wire logic                                    rst_n,
  input wire cwmp_apb_req_t                           apbReq,
  input wire cwmp_apb_rsp_t                           apbRsp,
  input wire logic [CWMP_CH_NUM-1:0][CWMP_CODE_W-1:0] mixerPhaseCode,
  input wire logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0] mixerPhaseTap,
  input wire logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]  mixerPhaseTenthDeg,
  input wire logic                                    continuousWaveModeSelect,
  input wire logic [1:0]                              continuousWaveClockRatio,
  input wire logic [CWMP_MULT_W-1:0]                  continuousWaveClockMultiple
);
  // ****
  // Properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire acc = apbReq.psel && apbReq.penable;
  wire wrFull = acc && apbReq.pwrite && apbReq.pstrb[1:0] == 2'b11;

  a_ready_access: assert property (acc |-> apbRsp.pready)
    else $error("no ready in access phase");
  a_ready_idle: assert property (!acc |-> !apbRsp.pready)
    else $error("ready outside access phase");
  a_write_low: assert property (wrFull && apbReq.paddr == CWMP_ADDR_PH0
    |=> mixerPhaseCode[3:0] == $past(apbReq.pwdata[15:0])) else $error("first reg not stored");
  a_write_high: assert property (wrFull && apbReq.paddr == CWMP_ADDR_PH3
    |=> mixerPhaseCode[15:12] == $past(apbReq.pwdata[15:0])) else $error("last reg not stored");
  a_code_hold: assert property (!(acc && apbReq.pwrite) |=> $stable(mixerPhaseCode))
    else $error("code changed without write");
  a_tap_cw: assert property (continuousWaveModeSelect
    |=> mixerPhaseTap[2] == (16'h0001 << $past(mixerPhaseCode[2]))) else $error("tap wrong");
  a_tap_tgc: assert property (!continuousWaveModeSelect |=> mixerPhaseTap == '0)
    else $error("tap active in tgc mode");
  a_deg_scale: assert property (rst_n
    |=> mixerPhaseTenthDeg[9] == 12'd225 * $past(mixerPhaseCode[9])) else $error("degrees wrong");
  a_clock_mult: assert property (rst_n |=> continuousWaveClockMultiple ==
    ($past(continuousWaveClockRatio) == 2'b11 ? 5'd1 : 5'd16 >> $past(continuousWaveClockRatio)))
    else $error("clock multiple wrong");
endmodule : cwmp_mixer_phase_regs_chk

bind cwmp_mixer_phase_regs cwmp_mixer_phase_regs_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .mixerPhaseCode(mixerPhaseCode), .mixerPhaseTap(mixerPhaseTap),
  .mixerPhaseTenthDeg(mixerPhaseTenthDeg), .continuousWaveModeSelect(continuousWaveModeSelect),
  .continuousWaveClockRatio(continuousWaveClockRatio),
  .continuousWaveClockMultiple(continuousWaveClockMultiple));

/* bench/cwmp_mixer_phase_regs_tb.sv */
`timescale 1ns/10ps
module cwmp_mixer_phase_regs_tb;
  import cwmp_pkg::*;
  logic                                    sys_clk = 1'b0;
  logic                                    rst_n   = 1'b0;
  cwmp_apb_req_t                           apbReq  = '0;
  cwmp_apb_rsp_t                           apbRsp;
  logic [CWMP_CH_NUM-1:0][CWMP_CODE_W-1:0] code;
  logic [CWMP_CH_NUM-1:0][CWMP_CH_NUM-1:0] tap;
  logic [CWMP_CH_NUM-1:0][CWMP_DEG_W-1:0]  deg;
  logic                                    mode;
  logic [1:0]                              ratio;
  logic [CWMP_MULT_W-1:0]                  mult;
  logic [31:0]                             rd;
  logic                                    err;
  logic [15:0]                             pat;
  int                                      miscompares = 0;
  int                                      tests_run   = 0;

  cwmp_mixer_phase_regs u_cwmp_mixer_phase_regs (.sys_clk(sys_clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .mixerPhaseCode(code), .mixerPhaseTap(tap),
    .mixerPhaseTenthDeg(deg), .continuousWaveModeSelect(mode),
    .continuousWaveClockRatio(ratio), .continuousWaveClockMultiple(mult));

  initial forever #12.5 sys_clk = ~sys_clk;

  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d, pstrb:s};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task automatic settle;
    @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, CWMP_ADDR_PH0 + 12'(4 * r), '0, 4'h0);
      chk("reset read", rd, 32'h0000_0000);
    end
    for (int r = 0; r < 4; r++) begin
      pat = {4'(4 * r + 3), 4'(4 * r + 2), 4'(4 * r + 1), 4'(4 * r)};
      apb(1'b1, CWMP_ADDR_PH0 + 12'(4 * r), {16'hFFFF, pat}, 4'hF);
      apb(1'b0, CWMP_ADDR_PH0 + 12'(4 * r), '0, 4'h0);
      chk("phase reg", rd, {16'h0000, pat});
    end
    settle;
    for (int c = 0; c < 16; c++) begin
      chk("code", 32'(code[c]), 32'(c));
      chk("degrees", 32'(deg[c]), 32'(225 * c));
    end
    for (int q = 0; q < 4; q++) begin
      apb(1'b1, CWMP_ADDR_CTRL, 32'({q[1:0], 1'b1}), 4'h1);
      apb(1'b0, CWMP_ADDR_CTRL, '0, 4'h0);
      chk("ctrl", rd, 32'({q[1:0], 1'b1}));
      settle;
      chk("mode ratio", 32'({ratio, mode}), 32'({q[1:0], 1'b1}));
      chk("multiple", 32'(mult), 32'(q == 3 ? 1 : 16 >> q));
      chk("tap", 32'(tap[5]), 32'h0000_0020);
    end
    apb(1'b1, CWMP_ADDR_CTRL, 32'h0000_0000, 4'h1);
    settle;
    chk("tgc tap", 32'(tap[5]), 32'h0000_0000);
    chk("tgc code", 32'(code[5]), 32'h0000_0005);
    apb(1'b1, CWMP_ADDR_PH0, 32'h0000_AAAA, 4'h1);
    apb(1'b0, CWMP_ADDR_PH0, '0, 4'h0);
    chk("byte lane", rd, 32'h0000_32AA);
    apb(1'b0, 12'h314, '0, 4'h0);
    chk("unmapped err", 32'(err), 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, 12'h305, 32'h0000_5555, 4'hF);
    apb(1'b0, CWMP_ADDR_PH0, '0, 4'h0);
    chk("misaligned", rd, 32'h0000_32AA);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, CWMP_ADDR_PH3, '0, 4'h0);
    chk("second reset", rd, 32'h0000_0000);
    chk("second reset code", code[15:8], 32'h0000_0000);
    complete_run;
  end
endmodule : cwmp_mixer_phase_regs_tb
